// [deser_pkg.sv]
package deser_pkg;
    // register indices, not byte addresses (byte address = 4 * index)
    localparam logic [7:0] IDX_GEN_CFG = 8'h02;
    localparam logic [7:0] IDX_PORT_LOCK_STATUS = 8'h4D;
    localparam logic [7:0] IDX_PORT_CFG = 8'h6D;
    localparam logic [7:0] IDX_PAGE = 8'hB0;
    localparam logic [7:0] IDX_INDEX = 8'hB1;
    localparam logic [7:0] IDX_DATA = 8'hB2;
    localparam logic [7:0] IDX_IRQ_STS = 8'hC0;
    localparam logic [7:0] IDX_IRQ_MASK = 8'hC1;
    localparam logic [7:0] IDX_MON_STS = 8'hC2;
    // general configuration fields
    localparam int GEN_OE_VAL = 0;
    localparam int GEN_OE_OVR = 1;
    localparam int GEN_OSS_VAL = 2;
    localparam int GEN_OSS_OVR = 3;
    localparam int GEN_GPIO_LOCK = 4;
    // port configuration fields
    localparam int PCFG_COAX = 2;
    // receive mode encodings
    localparam logic [1:0] MODE_LF12 = 2'h0;
    localparam logic [1:0] MODE_HF12 = 2'h1;
    localparam logic [1:0] MODE_TEN = 2'h2;
    // indirect monitor programming values
    localparam logic [7:0] PG_MON = 8'h14;
    localparam logic [7:0] PG_PORT = 8'h18;
    localparam logic [7:0] IX_ENABLE = 8'h00;
    localparam logic [7:0] IX_MUX = 8'h02;
    localparam logic [7:0] IX_MUX_B = 8'h03;
    localparam logic [7:0] IX_MUX_C = 8'h04;
    localparam logic [7:0] IX_PORT_A = 8'h0F;
    localparam logic [7:0] IX_PORT_B = 8'h10;
    localparam logic [7:0] DV_ENABLE = 8'h80;
    localparam logic [7:0] DV_MUX_P0 = 8'h20;
    localparam logic [7:0] DV_MUX_P1 = 8'hA0;
    localparam logic [7:0] DV_MUX_BC = 8'h28;
    localparam logic [7:0] DV_PORT_A = 8'h01;
    localparam logic [7:0] DV_PORT_B = 8'h02;
    // reset values
    localparam logic [7:0] RST_GEN_CFG = 8'h00;
    localparam logic [7:0] RST_BYTE = 8'h00;
    // timing: link lost when no link-clock edge for this long
    localparam int LINK_TIMEOUT_NS = 1000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int LINK_TIMEOUT_CYC = LINK_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int EQ_MAX = 15;
endpackage : deser_pkg

// [deser_mode_output_ctrl.sv]
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ps
module deser_mode_output_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic [2:0] mode_strap_i,
    input wire logic power_down_bar_i,
    input wire logic output_enable_pin_i,
    input wire logic output_state_select_i,
    input wire logic link_clk_i,
    input wire logic ser_pclk_active_i,
    input wire logic [1:0] rx_serial_i,
    input wire logic [11:0] rx_data_i,
    input wire logic rx_pass_i,
    output logic [11:0] data_o,
    output logic data_oe_n_o,
    output logic pclk_o,
    output logic pclk_oe_n_o,
    output logic lock_o,
    output logic lock_oe_n_o,
    output logic pass_o,
    output logic pass_oe_n_o,
    output logic link_rate_clk_o,
    output logic gpio_lock_o,
    output logic remote_i2c_en_o,
    output logic [3:0] eq_setting_o,
    output logic monitor_loop_output_o,
    output logic irq_o
);
    typedef enum logic [1:0] {ACQUIRE, LINKED} link_state_t;

    // synchronisers: first stage read only by the second
    logic [2:0] strap_s1, strap_s2;
    logic pdb_s1, pdb_s2, oen_s1, oen_s2, oss_s1, oss_s2;
    logic lk_s1, lk_s2, lk_d, act_s1, act_s2;
    logic [1:0] ser_s1, ser_s2;
    always_ff @(posedge clk_i) begin
        strap_s1 <= mode_strap_i;
        strap_s2 <= strap_s1;
        pdb_s1 <= power_down_bar_i;
        pdb_s2 <= pdb_s1;
        oen_s1 <= output_enable_pin_i;
        oen_s2 <= oen_s1;
        oss_s1 <= output_state_select_i;
        oss_s2 <= oss_s1;
        lk_s1 <= link_clk_i;
        lk_s2 <= lk_s1;
        lk_d <= lk_s2;
        act_s1 <= ser_pclk_active_i;
        act_s2 <= act_s1;
        ser_s1 <= rx_serial_i;
        ser_s2 <= ser_s1;
    end

    // registers
    logic [7:0] gen_cfg, port_cfg, page, index, idata, irq_sts, irq_mask;
    logic [7:0] mon_en_r, mon_mux_r, mon_b_r, mon_c_r, mon_pa_r, mon_pb_r;
    logic strap_loaded, reset_seen;

    // strap decode
    wire strap_reserved = (strap_s2[1:0] == 2'h0);
    wire strap_coax = strap_s2[2];
    wire [1:0] strap_mode = 2'(strap_s2[1:0] - 2'h1);

    // wishbone decode
    wire [7:0] reg_idx = wb_adr_i[9:2];
    wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr_lane = bus_req && wb_we_i && wb_sel_i[0];
    wire wr_gen = wr_lane && (reg_idx == deser_pkg::IDX_GEN_CFG);
    wire wr_pcfg = wr_lane && (reg_idx == deser_pkg::IDX_PORT_CFG);
    wire wr_page = wr_lane && (reg_idx == deser_pkg::IDX_PAGE);
    wire wr_index = wr_lane && (reg_idx == deser_pkg::IDX_INDEX);
    wire wr_data = wr_lane && (reg_idx == deser_pkg::IDX_DATA);
    wire wr_isit = wr_lane && (reg_idx == deser_pkg::IDX_IRQ_STS);
    wire wr_imask = wr_lane && (reg_idx == deser_pkg::IDX_IRQ_MASK);

    // link activity: edges of the sampled link clock
    wire lk_edge = lk_s2 ^ lk_d;
    logic [7:0] idle_cnt;
    link_state_t link_st;
    wire linked = (link_st == LINKED);
    wire serial_static = !linked;

    // output control selection
    wire oe_eff = gen_cfg[deser_pkg::GEN_OE_OVR] ? gen_cfg[deser_pkg::GEN_OE_VAL] : oen_s2;
    wire oss_eff = gen_cfg[deser_pkg::GEN_OSS_OVR] ? gen_cfg[deser_pkg::GEN_OSS_VAL] : oss_s2;
    wire [1:0] mode = port_cfg[1:0];
    // lock pin qualification per mode
    wire lock_pin = linked && ((mode != deser_pkg::MODE_HF12) || act_s2);

    // register writes; strap captured once after reset release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gen_cfg <= deser_pkg::RST_GEN_CFG;
            port_cfg <= deser_pkg::RST_BYTE;
            strap_loaded <= 1'b0;
            reset_seen <= 1'b0;
        end else begin
            reset_seen <= 1'b1;
            if (wr_gen)
                gen_cfg <= wb_dat_i[7:0];
            if (wr_pcfg) begin
                port_cfg <= wb_dat_i[7:0];
            end else if (reset_seen && !strap_loaded) begin
                strap_loaded <= 1'b1;
                port_cfg <= {5'h00, strap_coax, strap_reserved ? deser_pkg::MODE_LF12 : strap_mode};
            end
        end
    end

    // indirect monitor registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            page <= deser_pkg::RST_BYTE;
            index <= deser_pkg::RST_BYTE;
            idata <= deser_pkg::RST_BYTE;
            mon_en_r <= deser_pkg::RST_BYTE;
            mon_mux_r <= deser_pkg::RST_BYTE;
            mon_b_r <= deser_pkg::RST_BYTE;
            mon_c_r <= deser_pkg::RST_BYTE;
            mon_pa_r <= deser_pkg::RST_BYTE;
            mon_pb_r <= deser_pkg::RST_BYTE;
        end else begin
            if (wr_page)
                page <= wb_dat_i[7:0];
            if (wr_index)
                index <= wb_dat_i[7:0];
            if (wr_data) begin
                idata <= wb_dat_i[7:0];
                if (page == deser_pkg::PG_MON && index == deser_pkg::IX_ENABLE)
                    mon_en_r <= wb_dat_i[7:0];
                if (page == deser_pkg::PG_MON && index == deser_pkg::IX_MUX)
                    mon_mux_r <= wb_dat_i[7:0];
                if (page == deser_pkg::PG_MON && index == deser_pkg::IX_MUX_B)
                    mon_b_r <= wb_dat_i[7:0];
                if (page == deser_pkg::PG_MON && index == deser_pkg::IX_MUX_C)
                    mon_c_r <= wb_dat_i[7:0];
                if (page == deser_pkg::PG_PORT && index == deser_pkg::IX_PORT_A)
                    mon_pa_r <= wb_dat_i[7:0];
                if (page == deser_pkg::PG_PORT && index == deser_pkg::IX_PORT_B)
                    mon_pb_r <= wb_dat_i[7:0];
            end
        end
    end

    // monitor driver runs only once the full sequence is in place
    wire mon_ready = (mon_en_r == deser_pkg::DV_ENABLE) && (mon_b_r == deser_pkg::DV_MUX_BC)
        && (mon_c_r == deser_pkg::DV_MUX_BC) && (mon_pa_r == deser_pkg::DV_PORT_A)
        && (mon_pb_r == deser_pkg::DV_PORT_B);
    wire mon_port1 = (mon_mux_r == deser_pkg::DV_MUX_P1);
    wire mon_sel_ok = mon_port1 || (mon_mux_r == deser_pkg::DV_MUX_P0);

    // link acquisition and loss detection
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            link_st <= ACQUIRE;
            idle_cnt <= 8'h00;
        end else begin
            idle_cnt <= lk_edge ? 8'h00 : (idle_cnt == 8'hFF ? idle_cnt : 8'(idle_cnt + 8'h01));
            case (link_st)
                ACQUIRE: if (lk_edge && idle_cnt < 8'(deser_pkg::LINK_TIMEOUT_CYC))
                    link_st <= LINKED;
                LINKED: if (idle_cnt >= 8'(deser_pkg::LINK_TIMEOUT_CYC))
                    link_st <= ACQUIRE;
                default: link_st <= ACQUIRE;
            endcase
        end
    end

    // equalizer: steps while linked, cleared on loss of lock
    logic [3:0] eq;
    logic eq_dir;
    always_ff @(posedge clk_i) begin
        if (rst_i || !linked) begin
            eq <= 4'h0;
            eq_dir <= 1'b1;
        end else if (lk_edge) begin
            eq <= eq_dir ? 4'(eq + 4'h1) : 4'(eq - 4'h1);
            if (eq == 4'(deser_pkg::EQ_MAX - 1) && eq_dir)
                eq_dir <= 1'b0;
            else if (eq == 4'h1 && !eq_dir)
                eq_dir <= 1'b1;
        end
    end

    // link-rate clock from link clock edges: /2 (every other), x2/3 (drop every third), x1
    // a mod-3 phase cannot give a divide by two, so a separate half bit paces that mode
    logic [1:0] ph;
    logic half;
    logic lrc;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ph <= 2'h0;
            half <= 1'b0;
            lrc <= 1'b0;
        end else if (lk_edge) begin
            ph <= (ph == 2'h2) ? 2'h0 : 2'(ph + 2'h1);
            half <= ~half;
            case (mode)
                deser_pkg::MODE_TEN: lrc <= half ? ~lrc : lrc;
                deser_pkg::MODE_HF12: lrc <= (ph == 2'h2) ? lrc : ~lrc;
                default: lrc <= ~lrc;
            endcase
        end
    end

    // interrupts: lock gained, lock lost; set wins over write-one clear
    link_state_t link_st_prev;
    wire [7:0] irq_ev = {6'h00, linked && link_st_prev == ACQUIRE, !linked && link_st_prev == LINKED};
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            link_st_prev <= ACQUIRE;
            irq_sts <= deser_pkg::RST_BYTE;
            irq_mask <= deser_pkg::RST_BYTE;
        end else begin
            link_st_prev <= link_st;
            irq_sts <= (irq_sts & ~(wr_isit ? wb_dat_i[7:0] : 8'h00)) | irq_ev;
            if (wr_imask)
                irq_mask <= wb_dat_i[7:0];
        end
    end

    // read mux
    wire [7:0] rd_byte =
        (reg_idx == deser_pkg::IDX_GEN_CFG) ? gen_cfg :
        (reg_idx == deser_pkg::IDX_PORT_LOCK_STATUS) ? {7'h00, linked} :
        (reg_idx == deser_pkg::IDX_PORT_CFG) ? port_cfg :
        (reg_idx == deser_pkg::IDX_PAGE) ? page :
        (reg_idx == deser_pkg::IDX_INDEX) ? index :
        (reg_idx == deser_pkg::IDX_DATA) ? idata :
        (reg_idx == deser_pkg::IDX_IRQ_STS) ? irq_sts :
        (reg_idx == deser_pkg::IDX_IRQ_MASK) ? irq_mask :
        (reg_idx == deser_pkg::IDX_MON_STS) ? {4'h0, eq} : 8'h00;

    // bus answer one cycle after the request; unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= {24'h00_0000, rd_byte};
        end
    end

    // parallel output states
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock_o <= 1'b0;
            pass_o <= 1'b0;
            data_o <= 12'h000;
            pclk_o <= 1'b0;
            {lock_oe_n_o, pass_oe_n_o, data_oe_n_o, pclk_oe_n_o} <= 4'hF;
        end else if (!pdb_s2) begin
            {lock_oe_n_o, pass_oe_n_o, data_oe_n_o, pclk_oe_n_o} <= 4'hF;
            lock_o <= 1'b0;
            data_o <= 12'h000;
            pclk_o <= 1'b0;
        end else if (!oe_eff) begin
            lock_oe_n_o <= 1'b0;
            lock_o <= lock_pin;
            pass_oe_n_o <= !oss_eff;
            pass_o <= 1'b0;
            {data_oe_n_o, pclk_oe_n_o} <= {!oss_eff, !oss_eff};
            data_o <= 12'h000;
            pclk_o <= 1'b0;
        end else begin
            {lock_oe_n_o, pass_oe_n_o, data_oe_n_o, pclk_oe_n_o} <= 4'h0;
            lock_o <= lock_pin;
            if (serial_static && oss_eff) begin
                data_o <= 12'h000;
                pclk_o <= 1'b0;
            end else if (linked && !oss_eff) begin
                data_o <= 12'h000;
                pclk_o <= 1'b0;
                pass_o <= 1'b1;
            end else if (linked) begin
                data_o <= rx_data_i;
                pclk_o <= lrc;
                pass_o <= rx_pass_i;
            end else begin
                data_o <= 12'h000;
                pclk_o <= 1'b0;
                pass_o <= 1'b0;
            end
        end
    end

    // misc status outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gpio_lock_o <= 1'b0;
            remote_i2c_en_o <= 1'b0;
            eq_setting_o <= 4'h0;
            monitor_loop_output_o <= 1'b0;
            link_rate_clk_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            gpio_lock_o <= gen_cfg[deser_pkg::GEN_GPIO_LOCK] && linked;
            remote_i2c_en_o <= linked;
            eq_setting_o <= eq;
            monitor_loop_output_o <= mon_ready && mon_sel_ok && ser_s2[mon_port1];
            link_rate_clk_o <= lrc;
            irq_o <= |(irq_sts & ~irq_mask); // a set mask bit silences its event
        end
    end

    AST_LOSS_RESETS_EQ: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(linked) |=> (eq == 4'h0)) else $error("equalizer not reset on loss of lock");
    AST_PDB_HIZ: assert property (@(posedge clk_i) disable iff (rst_i)
        !pdb_s2 |=> (lock_oe_n_o && pass_oe_n_o && data_oe_n_o && pclk_oe_n_o))
        else $error("outputs driven during power-down");
    AST_STATIC_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
        (pdb_s2 && oe_eff && oss_eff && serial_static) |=> (!lock_o && data_o == 12'h000
        && $stable(pass_o))) else $error("static input outputs wrong");
    AST_HF_LOCK: assert property (@(posedge clk_i) disable iff (rst_i)
        (pdb_s2 && oe_eff && mode == deser_pkg::MODE_HF12 && !act_s2) |=> !lock_o)
        else $error("lock high without pixel clock in hf mode");
    AST_LF_LOCK: assert property (@(posedge clk_i) disable iff (rst_i)
        (pdb_s2 && oe_eff && mode != deser_pkg::MODE_HF12 && linked) |=> lock_o)
        else $error("lock low while linked");
    AST_I2C_GATE: assert property (@(posedge clk_i) disable iff (rst_i)
        remote_i2c_en_o |-> $past(linked)) else $error("remote i2c before lock");
    AST_OVR_OE: assert property (@(posedge clk_i) disable iff (rst_i)
        (pdb_s2 && gen_cfg[deser_pkg::GEN_OE_OVR] && !gen_cfg[deser_pkg::GEN_OE_VAL])
        |=> data_oe_n_o == !$past(oss_eff)) else $error("override ignored");
    AST_PCFG_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_pcfg |=> port_cfg == $past(wb_dat_i[7:0])) else $error("port config write lost");
endmodule : deser_mode_output_ctrl

// [ser_model.sv]
`timescale 1ns/1ps
// far-side serializer: link clock only while running, payload latched per link cycle
module ser_model (
    input wire logic clk_i,
    input wire logic run_i,
    input wire logic pclk_act_i,
    input wire logic [11:0] pix_i,
    input wire logic pass_i,
    output logic link_clk_o,
    output logic pclk_active_o,
    output logic [1:0] rx_serial_o,
    output logic [11:0] rx_data_o,
    output logic pass_o
);
    logic link_q;
    // the odd offset keeps link edges clear of local clock edges
    initial begin
        link_clk_o = 1'b0;
        rx_data_o = 12'h000;
        pass_o = 1'b0;
        link_q = 1'b0;
        #1.3;
        forever begin
            #62.5;
            link_clk_o = run_i ? ~link_clk_o : 1'b0;
        end
    end
    // a static line keeps toggling data so stale words cannot pass for valid ones
    always @(posedge clk_i) begin
        link_q <= link_clk_o;
        if (!run_i) begin
            rx_data_o <= ~rx_data_o;
        end else if (link_clk_o && !link_q) begin
            rx_data_o <= pix_i;
            pass_o <= pass_i;
        end
    end
    // channel 0 carries the toggling link, channel 1 a steady level
    assign pclk_active_o = run_i & pclk_act_i;
    assign rx_serial_o = {run_i, link_clk_o};
endmodule : ser_model

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o;
    logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o;
    logic [3:0] wb_sel_i = 4'h0;
    logic [2:0] mode_strap_i = 3'h6;
    logic power_down_bar_i = 1'b1, output_enable_pin_i = 1'b1, output_state_select_i = 1'b1;
    logic run = 1'b0, pact = 1'b0, pass = 1'b0;
    logic [11:0] pix = 12'h000;
    logic link_clk_i, ser_pclk_active_i, rx_pass_i;
    logic [1:0] rx_serial_i;
    logic [11:0] rx_data_i, data_o;
    logic data_oe_n_o, pclk_o, pclk_oe_n_o, lock_o, lock_oe_n_o, pass_o, pass_oe_n_o;
    logic link_rate_clk_o, gpio_lock_o, remote_i2c_en_o, monitor_loop_output_o, irq_o;
    logic [3:0] eq_setting_o;
    int n_mismatch = 0;
    int checked = 0;

    deser_mode_output_ctrl u_deser_mode_output_ctrl (
        .clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i,
        .wb_stb_i, .wb_ack_o, .mode_strap_i, .power_down_bar_i, .output_enable_pin_i,
        .output_state_select_i, .link_clk_i, .ser_pclk_active_i, .rx_serial_i, .rx_data_i,
        .rx_pass_i, .data_o, .data_oe_n_o, .pclk_o, .pclk_oe_n_o, .lock_o, .lock_oe_n_o,
        .pass_o, .pass_oe_n_o, .link_rate_clk_o, .gpio_lock_o, .remote_i2c_en_o,
        .eq_setting_o, .monitor_loop_output_o, .irq_o
    );
    ser_model u_ser_model (
        .clk_i, .run_i(run), .pclk_act_i(pact), .pix_i(pix), .pass_i(pass),
        .link_clk_o(link_clk_i), .pclk_active_o(ser_pclk_active_i), .rx_serial_o(rx_serial_i),
        .rx_data_o(rx_data_i), .pass_o(rx_pass_i)
    );

    // 200 MHz clock
    always #2.5 clk_i = ~clk_i;

    task automatic complete_run;
        $display("checked %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    // one classic cycle; read data is taken at the very edge that shows ack
    task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d,
                      input logic [3:0] sel, output logic [31:0] q);
        int n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= sel;
        wb_adr_i <= {22'h0, idx, 2'h0};
        wb_dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            n_mismatch++;
            complete_run();
        end
    endtask : wb

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, idx, d, 4'hF, q);
    endtask : wr

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, idx, 8'h00, 4'hF, q);
        chk(q, exp);
    endtask : rd_chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc

    task automatic do_reset;
        rst_i <= 1'b1;
        cyc(5);
        rst_i <= 1'b0;
        cyc(3);
    endtask : do_reset

    // every strap number, the reserved ones too, each through a fresh reset
    task automatic t_strap;
        logic [2:0] s;
        logic [31:0] e;
        for (int i = 0; i < 8; i++) begin
            s = 3'(i);
            e = {29'h0, s[2], (s[1:0] == 2'h0) ? 2'h0 : s[1:0] - 2'h1};
            mode_strap_i <= s;
            do_reset();
            rd_chk(deser_pkg::IDX_PORT_CFG, e);
        end
        $display("strap test done");
    endtask : t_strap

    // reset values, an unmapped place and a write without the low lane
    task automatic t_regs;
        logic [31:0] q;
        rd_chk(deser_pkg::IDX_GEN_CFG, {24'h0, deser_pkg::RST_GEN_CFG});
        rd_chk(deser_pkg::IDX_PORT_LOCK_STATUS, 32'h0);
        for (int i = 0; i < 3; i++) rd_chk(deser_pkg::IDX_PAGE + 8'(i), {24'h0, deser_pkg::RST_BYTE});
        rd_chk(8'h3F, 32'h0);
        wr(deser_pkg::IDX_PORT_CFG, 8'h01);
        rd_chk(deser_pkg::IDX_PORT_CFG, 32'h01);
        wb(1'b1, deser_pkg::IDX_PORT_CFG, 8'h06, 4'hE, q);
        rd_chk(deser_pkg::IDX_PORT_CFG, 32'h01);
        wr(deser_pkg::IDX_PORT_CFG, 8'h04);
        rd_chk(deser_pkg::IDX_PORT_CFG, 32'h04);
        $display("register test done");
    endtask : t_regs

    // lock pin against mode and pixel-clock activity; status bit, gpio and i2c gate
    task automatic t_lock;
        logic [1:0] md[4] = '{deser_pkg::MODE_LF12, deser_pkg::MODE_HF12,
                              deser_pkg::MODE_HF12, deser_pkg::MODE_TEN};
        logic ac[4] = '{1'b0, 1'b0, 1'b1, 1'b0};
        logic ex[4] = '{1'b1, 1'b0, 1'b1, 1'b1};
        wr(deser_pkg::IDX_GEN_CFG, 8'h10);
        cyc(10);
        chk(remote_i2c_en_o, 32'h0);
        chk(gpio_lock_o, 32'h0);
        run <= 1'b1;
        cyc(60);
        for (int i = 0; i < 4; i++) begin
            wr(deser_pkg::IDX_PORT_CFG, {6'h0, md[i]});
            pact <= ac[i];
            cyc(20);
            chk(lock_o, ex[i]);
            rd_chk(deser_pkg::IDX_PORT_LOCK_STATUS, 32'h1);
            chk(gpio_lock_o, 32'h1);
            chk(remote_i2c_en_o, 32'h1);
        end
        wr(deser_pkg::IDX_PORT_CFG, 8'h00);
        $display("lock test done");
    endtask : t_lock

    // link-rate clock toggles over 48 link-clock edges per mode; ends in low-freq 12-bit
    task automatic t_rate;
        logic [1:0] md[3] = '{deser_pkg::MODE_TEN, deser_pkg::MODE_HF12, deser_pkg::MODE_LF12};
        int ex[3] = '{24, 32, 48};
        int edges;
        int tog;
        logic lk_q;
        logic rc_q;
        for (int i = 0; i < 3; i++) begin
            wr(deser_pkg::IDX_PORT_CFG, {6'h0, md[i]});
            cyc(20);
            edges = 0;
            tog = 0;
            lk_q = link_clk_i;
            rc_q = link_rate_clk_o;
            for (int n = 0; n < 2000 && edges < 49; n++) begin
                @(posedge clk_i);
                if (edges > 0 && link_rate_clk_o !== rc_q) tog++;
                if (link_clk_i !== lk_q) edges++;
                lk_q = link_clk_i;
                rc_q = link_rate_clk_o;
            end
            if (edges < 49) begin
                n_mismatch++;
                complete_run();
            end
            chk(tog, ex[i]);
        end
        $display("rate test done");
    endtask : t_rate

    // output states: active, register override, static input, power-down
    task automatic t_out;
        pix <= 12'hA5C;
        pass <= 1'b1;
        cyc(60);
        chk(data_o, 32'hA5C);
        chk({lock_o, pass_o, data_oe_n_o, pclk_oe_n_o}, 32'hC);
        wr(deser_pkg::IDX_GEN_CFG, 8'h1A);
        cyc(8);
        chk({data_oe_n_o, lock_oe_n_o}, 32'h2);
        output_enable_pin_i <= 1'b0;
        output_state_select_i <= 1'b0;
        wr(deser_pkg::IDX_GEN_CFG, 8'h1F);
        cyc(8);
        chk({data_oe_n_o, lock_oe_n_o}, 32'h0);
        output_enable_pin_i <= 1'b1;
        output_state_select_i <= 1'b1;
        wr(deser_pkg::IDX_GEN_CFG, 8'h10);
        run <= 1'b0;
        cyc(260);
        chk({lock_o, pass_o, pclk_o}, 32'h2);
        chk(data_o, 32'h0);
        chk(eq_setting_o, 32'h0);
        rd_chk(deser_pkg::IDX_PORT_LOCK_STATUS, 32'h0);
        power_down_bar_i <= 1'b0;
        cyc(8);
        chk({lock_oe_n_o, pass_oe_n_o, data_oe_n_o, pclk_oe_n_o}, 32'hF);
        power_down_bar_i <= 1'b1;
        $display("output test done");
    endtask : t_out

    // sticky lock events, masking and write-one-to-clear
    task automatic t_irq;
        wr(deser_pkg::IDX_IRQ_MASK, 8'h00);
        wr(deser_pkg::IDX_IRQ_STS, 8'h03);
        rd_chk(deser_pkg::IDX_IRQ_STS, 32'h0);
        chk(irq_o, 32'h0);
        run <= 1'b1;
        cyc(60);
        rd_chk(deser_pkg::IDX_IRQ_STS, 32'h2);
        chk(irq_o, 32'h1);
        wr(deser_pkg::IDX_IRQ_MASK, 8'h02);
        cyc(3);
        chk(irq_o, 32'h0);
        wr(deser_pkg::IDX_IRQ_MASK, 8'h00);
        wr(deser_pkg::IDX_IRQ_STS, 8'h02);
        cyc(3);
        chk(irq_o, 32'h0);
        run <= 1'b0;
        cyc(260);
        rd_chk(deser_pkg::IDX_IRQ_STS, 32'h1);
        chk(irq_o, 32'h1);
        $display("interrupt test done");
    endtask : t_irq

    // monitor stays quiet until the full indirect sequence, then follows the chosen channel
    task automatic t_mon;
        logic [7:0] ra[14] = '{8'hB0, 8'hB1, 8'hB2, 8'hB1, 8'hB2, 8'hB1, 8'hB2,
                               8'hB1, 8'hB2, 8'hB0, 8'hB1, 8'hB2, 8'hB1, 8'hB2};
        logic [7:0] rv[14] = '{8'h14, 8'h00, 8'h80, 8'h02, 8'h20, 8'h03, 8'h28,
                               8'h04, 8'h28, 8'h18, 8'h0F, 8'h01, 8'h10, 8'h02};
        int hi;
        int lo;
        run <= 1'b1;
        cyc(60);
        chk(monitor_loop_output_o, 32'h0);
        for (int p = 1; p >= 0; p--) begin
            rv[4] = (p == 1) ? 8'hA0 : 8'h20;
            for (int i = 0; i < 14; i++) wr(ra[i], rv[i]);
            hi = 0;
            lo = 0;
            repeat (200) begin
                @(posedge clk_i);
                if (monitor_loop_output_o === 1'b1) hi++;
                else if (monitor_loop_output_o === 1'b0) lo++;
            end
            chk({hi > 0, lo > 0}, (p == 1) ? 32'h2 : 32'h3);
        end
        $display("monitor test done");
    endtask : t_mon

    // main sequence
    initial begin
        do_reset();
        t_strap();
        t_regs();
        t_lock();
        t_rate();
        t_out();
        t_irq();
        t_mon();
        complete_run();
    end

    // guard against a hang anywhere in the run
    initial begin
        #400000;
        n_mismatch++;
        complete_run();
    end
endmodule : tb_top
